/* File: src/sbcms_params.svh */
`ifndef SBCMS_PARAMS_SVH
`define SBCMS_PARAMS_SVH

`define SBCMS_CLK_MHZ          250
`define SBCMS_TRD_US           10
`define SBCMS_TRD_CYC          (`SBCMS_TRD_US * `SBCMS_CLK_MHZ)
`define SBCMS_TLW_MS           200
`define SBCMS_TLW_CYC          (`SBCMS_TLW_MS * 1000 * `SBCMS_CLK_MHZ)
`define SBCMS_FRAME_BITS       16
`define SBCMS_MODE_W           3
`define SBCMS_WD_FAIL_LIMIT    2

`endif

/* File: src/sbcms_pkg.sv */
package sbcms_pkg;
   typedef enum logic [2:0]
   {
      SBCMS_INIT     = 3'h0,
      SBCMS_NORMAL   = 3'h1,
      SBCMS_STOP     = 3'h2,
      SBCMS_SLEEP    = 3'h3,
      SBCMS_RESTART  = 3'h4,
      SBCMS_FAILSAFE = 3'h5
   } sbcms_mode_t;

   typedef struct packed
   {
      logic wake_can;
      logic wake_lin;
      logic wake_inputs;
   } sbcms_wake_t;

   typedef struct packed
   {
      logic        valid;
      logic [15:0] data;
   } sbcms_frame_t;
endpackage

/* File: src/sbcms_delay_timer.sv */
`timescale 1ns/1ps
`include "sbcms_params.svh"
// ---------------------------------------------
// Down counter with start, enable and done
// ---------------------------------------------
module sbcms_delay_timer
#(
   parameter int W = 32
)
(
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic         start,
   input  wire logic         run,
   input  wire logic [W-1:0] load,
   output logic              done
);
   logic [W-1:0] cnt_ff;
   logic         act_ff;
   wire          last = act_ff && run && (cnt_ff <= W'(1));

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff <= '0;
         act_ff <= 1'b0;
      end
      else if (start)
      begin
         cnt_ff <= load;
         act_ff <= 1'b1;
      end
      else if (last)
      begin
         cnt_ff <= '0;
         act_ff <= 1'b0;
      end
      else if (act_ff && run)
         cnt_ff <= cnt_ff - W'(1);
   end

   assign done = last;
endmodule

/* File: src/sbcms_mode_ctrl.sv */
`timescale 1ns/1ps
`include "sbcms_params.svh"
// Function
// [R1] Six modes: init, normal, stop, sleep, restart, failsafe
// [R2] Power-up and soft reset enter init
// [R3] Stop keeps main regulator on
// [R4] Sleep switches main regulator off
// [R5] Wake, watchdog failure, undervoltage enter restart
// [R6] Restart returns to normal after delay
// [R7] Critical failure enters failsafe, regulator off
// [R8] Failsafe held until wake or overtemperature clears
// [R9] Development mode freezes watchdog counter
// [R10] Host grounds test pin during init
// [R11] Watchdog failure reaction set by strap
// [R12] Sixteen-bit serial frames carry all commands; mode select comes on mode_sel and mode_sel_wr instead
// [R13] Mode select cleared passing through restart
// [R14] Any frame in init goes normal
// [R15] No trigger in long window: restart
// [R16] Wake events ignored in init
// [R17] One mode register, reset to init
module sbcms_mode_ctrl
#(
   parameter int TLW_CYC = `SBCMS_TLW_CYC,
   parameter int TRD_CYC = `SBCMS_TRD_CYC
)
(
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  soft_reset,
   input  wire sbcms_pkg::sbcms_frame_t spi_frame,
   input  wire logic [2:0]            mode_sel,
   input  wire logic                  mode_sel_wr,
   input  wire logic                  wd_trigger,
   input  wire logic                  wd_fail,
   input  wire logic                  reg_uv_reset,
   input  wire logic                  overtemp,
   input  wire sbcms_pkg::sbcms_wake_t wake_in,
   input  wire logic                  test_pin,
   input  wire logic                  cfg_pin,
   input  wire logic                  cfg_bit,
   output logic [2:0]                 mode,
   output logic [2:0]                 mode_sel_rd,
   output logic                       main_regulator_output,
   output logic                       mcu_reset_n,
   output logic                       dev_mode,
   output logic                       wd_count_run,
   output logic                       cfg_restart_on_wd
);
   import sbcms_pkg::*;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic [5:0] s1_ff;
   logic [5:0] s2_ff;
   logic [1:0] sync_cnt_ff;
   wire  [5:0] raw       = {test_pin, cfg_pin, overtemp, wake_in};
   wire        sync_full = (sync_cnt_ff == 2'h2);

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_ff       <= 6'h00;
         s2_ff       <= 6'h00;
         sync_cnt_ff <= 2'h0;
      end
      else
      begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         if (!sync_full)
            sync_cnt_ff <= sync_cnt_ff + 2'h1;
      end
   end

   wire test_s = s2_ff[5];
   wire cfg_s  = s2_ff[4];
   wire ot_s   = s2_ff[3];
   wire wake_s = |s2_ff[2:0];

   // ---------------------------------------------
   // State and straps
   // ---------------------------------------------
   sbcms_mode_t mode_ff;
   sbcms_mode_t nxt_mode;
   logic [2:0]  sel_ff;
   logic        dev_ff;
   logic        cfgp_ff;
   logic        strap_done_ff;
   logic        lw_open_ff;
   logic        fail_cnt_ff;
   logic        ot_seen_ff;

   wire in_init    = (mode_ff == SBCMS_INIT);
   wire in_restart = (mode_ff == SBCMS_RESTART);
   wire in_fs      = (mode_ff == SBCMS_FAILSAFE);
   wire in_sleep   = (mode_ff == SBCMS_SLEEP);

   // ---------------------------------------------
   // Timers
   // ---------------------------------------------
   logic lw_done;
   logic rd_done;
   wire  lw_start = in_init && !lw_open_ff;
   wire  rd_start = (nxt_mode == SBCMS_RESTART) && !in_restart;
   wire  fail_now = reg_uv_reset || (wd_fail && !dev_ff);

   sbcms_delay_timer #(.W(32)) u_lw
   (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (lw_start),
      .run     (!dev_ff && !wd_trigger),
      .load    (32'(TLW_CYC)),
      .done    (lw_done)
   );

   sbcms_delay_timer #(.W(32)) u_rd
   (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (rd_start || (in_restart && fail_now)),
      .run     (in_restart && !fail_now),
      .load    (32'(TRD_CYC)),
      .done    (rd_done)
   );

   wire lw_fail  = lw_done && in_init && !dev_ff;                            // [R15] [R9]
   wire wd_err   = (wd_fail && !dev_ff) || lw_fail;                          // [R9]
   wire wd_to_fs = !cfgp_ff && (cfg_bit || fail_cnt_ff);                     // [R11]

   // ---------------------------------------------
   // Next mode
   // ---------------------------------------------
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         SBCMS_INIT:
         begin
            if (lw_fail)
               nxt_mode = SBCMS_RESTART;                                     // [R15]
            else if (spi_frame.valid)
               nxt_mode = SBCMS_NORMAL;                                      // [R14] [R12]
         end
         SBCMS_NORMAL, SBCMS_STOP:
         begin
            if (wd_err && wd_to_fs)
               nxt_mode = SBCMS_FAILSAFE;                                    // [R7]
            else if (wd_err || reg_uv_reset)
               nxt_mode = SBCMS_RESTART;                                     // [R5]
            else if (mode_sel_wr && mode_sel == 3'(SBCMS_STOP))
               nxt_mode = SBCMS_STOP;                                        // [R3]
            else if (mode_sel_wr && mode_sel == 3'(SBCMS_SLEEP))
               nxt_mode = SBCMS_SLEEP;                                       // [R4]
            else if (mode_sel_wr && mode_sel == 3'(SBCMS_NORMAL))
               nxt_mode = SBCMS_NORMAL;
         end
         SBCMS_SLEEP:
         begin
            if (wake_s)
               nxt_mode = SBCMS_RESTART;                                     // [R5]
         end
         SBCMS_RESTART:
         begin
            if (rd_done)
               nxt_mode = SBCMS_NORMAL;                                      // [R6]
         end
         SBCMS_FAILSAFE:
         begin
            if (wake_s || (ot_seen_ff && !ot_s))
               nxt_mode = SBCMS_RESTART;                                     // [R8] [R5]
         end
         default:
            nxt_mode = SBCMS_INIT;
      endcase
      if (soft_reset)
         nxt_mode = SBCMS_INIT;                                              // [R2]
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         mode_ff <= SBCMS_INIT;                                              // [R17] [R2]
      else
         mode_ff <= nxt_mode;                                                // [R1]
   end

   // ---------------------------------------------
   // Mode select readback, straps, counters
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sel_ff        <= 3'h0;
         dev_ff        <= 1'b0;
         cfgp_ff       <= 1'b0;
         strap_done_ff <= 1'b0;
         lw_open_ff    <= 1'b0;
         fail_cnt_ff   <= 1'b0;
         ot_seen_ff    <= 1'b0;
      end
      else
      begin
         if (nxt_mode == SBCMS_RESTART)
            sel_ff <= 3'h0;                                                  // [R13]
         else if (nxt_mode != mode_ff)
            sel_ff <= 3'(nxt_mode);
         // Straps wait until the synchroniser holds real pin levels
         if (in_init && !strap_done_ff && sync_full)
         begin
            dev_ff        <= !test_s;                                        // [R10] [R9]
            cfgp_ff       <= cfg_s;                                          // [R11]
            strap_done_ff <= 1'b1;
         end
         lw_open_ff <= in_init && (nxt_mode == SBCMS_INIT);
         if (wd_err)
            fail_cnt_ff <= 1'b1;
         if (in_fs && ot_s)
            ot_seen_ff <= 1'b1;
         else if (!in_fs)
            ot_seen_ff <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Outputs; wake events unused in init
   // ---------------------------------------------
   assign mode                  = mode_ff;
   assign mode_sel_rd           = sel_ff;
   assign main_regulator_output = !(in_sleep || in_fs);                      // [R3] [R4] [R7]
   assign mcu_reset_n           = !(in_restart || in_fs);                    // [R5]
   assign dev_mode              = dev_ff;
   assign wd_count_run          = !dev_ff;                                   // [R9]
   assign cfg_restart_on_wd     = cfgp_ff;
   // Wake is only decoded in sleep and failsafe, so init drops it.        [R16]
endmodule

/* File: tb/sbcms_mcu_model.sv */
`timescale 1ns/1ps
// ----------------------------
// Microcontroller side
// ----------------------------
module sbcms_mcu_model
(
   input  wire logic               sys_clk,
   output sbcms_pkg::sbcms_frame_t spi_frame,
   output logic [2:0]              mode_sel,
   output logic                    mode_sel_wr,
   output logic                    wd_trigger,
   output logic                    test_pin
);
   import sbcms_pkg::*;
   initial
   begin
      spi_frame = '{valid: 1'b0, data: 16'h0000};
      mode_sel = 3'h0;
      mode_sel_wr = 1'b0;
      wd_trigger = 1'b1;
      test_pin = 1'b1;
   end
   task automatic send_frame(input logic [15:0] d);
      @(posedge sys_clk);
      spi_frame <= '{valid: 1'b1, data: d};
      @(posedge sys_clk);
      spi_frame <= '{valid: 1'b0, data: ~d};
   endtask
   task automatic write_mode(input logic [2:0] m);
      @(posedge sys_clk);
      mode_sel <= m;
      mode_sel_wr <= 1'b1;
      @(posedge sys_clk);
      mode_sel <= ~m;
      mode_sel_wr <= 1'b0;
   endtask
   task automatic set_pins(input logic trig, input logic dev);
      @(posedge sys_clk);
      wd_trigger <= trig;
      test_pin <= !dev;
   endtask
endmodule

/* File: tb/sbcms_mode_chk.sv */
`timescale 1ns/1ps
module sbcms_mode_chk
#(
   parameter int TRD_CYC = 20
)
(
   input wire logic                    sys_clk,
   input wire logic                    resetn,
   input wire logic                    soft_reset,
   input wire sbcms_pkg::sbcms_frame_t spi_frame,
   input wire logic                    wd_fail,
   input wire logic                    reg_uv_reset,
   input wire logic [2:0]              mode,
   input wire logic [2:0]              mode_sel_rd,
   input wire logic                    main_regulator_output,
   input wire logic                    mcu_reset_n,
   input wire logic                    dev_mode,
   input wire logic                    wd_count_run,
   input wire logic                    cfg_restart_on_wd
);
   import sbcms_pkg::*;
   logic [31:0] rst_cnt_ff;
   logic        quiet;
   assign quiet = !soft_reset && !wd_fail && !reg_uv_reset;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         rst_cnt_ff <= 32'h0;
      else
         rst_cnt_ff <= (mode == SBCMS_RESTART && quiet) ? rst_cnt_ff + 32'h1 : 32'h0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   mode_legal_a: assert property (mode <= 3'h5)
      else $error("mode code out of range");
   reg_mode_a: assert property (main_regulator_output == !(mode inside {SBCMS_SLEEP, SBCMS_FAILSAFE}))
      else $error("regulator wrong for mode");
   mcu_hold_a: assert property (mcu_reset_n == !(mode inside {SBCMS_RESTART, SBCMS_FAILSAFE}))
      else $error("mcu reset wrong for mode");
   soft_init_a: assert property (soft_reset |=> mode == SBCMS_INIT)
      else $error("soft reset missed init");
   init_frame_a: assert property (mode == SBCMS_INIT && spi_frame.valid && quiet |=> mode == SBCMS_NORMAL)
      else $error("frame in init missed normal");
   sel_clear_a: assert property (mode == SBCMS_RESTART |-> mode_sel_rd == 3'h0)
      else $error("mode select not cleared");
   restart_len_a: assert property (mode == SBCMS_NORMAL && $past(mode) == SBCMS_RESTART |-> rst_cnt_ff == TRD_CYC)
      else $error("restart length wrong");
   restart_max_a: assert property (rst_cnt_ff <= TRD_CYC)
      else $error("restart overstayed");
   wd_halt_a: assert property (wd_count_run == !dev_mode)
      else $error("watchdog run wrong");
   dev_wd_a: assert property (dev_mode && mode == SBCMS_NORMAL && wd_fail && !reg_uv_reset && !soft_reset
      |=> !(mode inside {SBCMS_RESTART, SBCMS_FAILSAFE}))
      else $error("watchdog failure acted in development mode");
   wd_strap_a: assert property (mode == SBCMS_NORMAL && wd_fail && !dev_mode && cfg_restart_on_wd && !soft_reset
      |=> mode == SBCMS_RESTART)
      else $error("strap reaction wrong");
   fs_exit_a: assert property (mode == SBCMS_FAILSAFE && !soft_reset |=> mode inside {SBCMS_FAILSAFE, SBCMS_RESTART})
      else $error("failsafe left wrongly");
   cover property (mode == SBCMS_SLEEP);
   cover property (mode == SBCMS_FAILSAFE);
   cover property (mode == SBCMS_NORMAL && $past(mode) == SBCMS_RESTART);
endmodule
bind sbcms_mode_ctrl sbcms_mode_chk #(.TRD_CYC(TRD_CYC)) u_chk
(
   .sys_clk, .resetn, .soft_reset, .spi_frame, .wd_fail, .reg_uv_reset, .mode, .mode_sel_rd,
   .main_regulator_output, .mcu_reset_n, .dev_mode, .wd_count_run, .cfg_restart_on_wd
);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import sbcms_pkg::*;
   localparam int TLW = 100;
   localparam int TRD = 20;
   logic         sys_clk, resetn, soft_reset, wd_fail, reg_uv_reset, overtemp, cfg_pin, cfg_bit;
   logic         mode_sel_wr, wd_trigger, test_pin, main_regulator_output, mcu_reset_n;
   logic         dev_mode, wd_count_run, cfg_restart_on_wd;
   logic [2:0]   mode_sel, mode, mode_sel_rd;
   sbcms_wake_t  wake_in;
   sbcms_frame_t spi_frame;
   int           num_errors = 0;
   int           n_compared = 0;
   sbcms_mode_ctrl #(.TLW_CYC(TLW), .TRD_CYC(TRD)) dut
   (
      .sys_clk, .resetn, .soft_reset, .spi_frame, .mode_sel, .mode_sel_wr, .wd_trigger, .wd_fail,
      .reg_uv_reset, .overtemp, .wake_in, .test_pin, .cfg_pin, .cfg_bit, .mode, .mode_sel_rd,
      .main_regulator_output, .mcu_reset_n, .dev_mode, .wd_count_run, .cfg_restart_on_wd
   );
   sbcms_mcu_model mcu
   (
      .sys_clk, .spi_frame, .mode_sel, .mode_sel_wr, .wd_trigger, .test_pin
   );
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      #1;
      for (int i = 0; i < lim && mode !== m; i++)
         tick(1);
   endtask
   task automatic pulse_fail();
      @(posedge sys_clk);
      wd_fail <= 1'b1;
      @(posedge sys_clk);
      wd_fail <= 1'b0;
   endtask
   task automatic drive_wake(input sbcms_wake_t w);
      @(posedge sys_clk);
      wake_in <= w;
      #1;
   endtask
   task automatic do_reset(input logic cp, input logic dv, input logic cb);
      @(posedge sys_clk);
      resetn <= 1'b0;
      cfg_pin <= cp;
      cfg_bit <= cb;
      mcu.set_pins(1'b1, dv);
      repeat (9) @(posedge sys_clk);
      resetn <= 1'b1;
      tick(4);
      chk("mode", mode, SBCMS_INIT);
      chk("reg", {2'h0, main_regulator_output}, 3'h1);
      chk("dev", {2'h0, dev_mode}, {2'h0, dv});
      chk("run", {2'h0, wd_count_run}, {2'h0, !dv});
      chk("cfg", {2'h0, cfg_restart_on_wd}, {2'h0, cp});
   endtask
   task automatic t_long_window();
      mcu.set_pins(1'b0, 1'b0);
      wait_mode(SBCMS_RESTART, TLW + 10);
      chk("mode", mode, SBCMS_RESTART);
      mcu.set_pins(1'b1, 1'b0);
      wait_mode(SBCMS_NORMAL, TRD + 5);
      chk("mode", mode, SBCMS_NORMAL);
   endtask
   task automatic t_init();
      @(posedge sys_clk);
      soft_reset <= 1'b1;
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      wake_in <= 3'h7;
      tick(6);
      chk("mode", mode, SBCMS_INIT);
      drive_wake(3'h0);
      mcu.send_frame(16'hA5C3);
      wait_mode(SBCMS_NORMAL, 4);
      chk("mode", mode, SBCMS_NORMAL);
   endtask
   task automatic t_modes();
      logic [2:0] seq [3] = '{SBCMS_STOP, SBCMS_NORMAL, SBCMS_SLEEP};
      foreach (seq[i])
      begin
         mcu.write_mode(seq[i]);
         wait_mode(seq[i], 4);
         chk("mode", mode, seq[i]);
         chk("reg", {2'h0, main_regulator_output}, {2'h0, seq[i] != SBCMS_SLEEP});
      end
      drive_wake(3'h4);
      wait_mode(SBCMS_RESTART, 6);
      chk("rst", {2'h0, mcu_reset_n}, 3'h0);
      chk("sel", mode_sel_rd, 3'h0);
      drive_wake(3'h0);
      wait_mode(SBCMS_NORMAL, TRD + 4);
      chk("sel", mode_sel_rd, SBCMS_NORMAL);
      pulse_fail();
      tick(1);
      chk("mode", mode, SBCMS_RESTART);
      wait_mode(SBCMS_NORMAL, TRD + 4);
      chk("mode", mode, SBCMS_NORMAL);
   endtask
   task automatic t_devmode();
      mcu.set_pins(1'b0, 1'b1);
      tick(TLW + 20);
      chk("mode", mode, SBCMS_INIT);
      mcu.send_frame(16'h0F1E);
      wait_mode(SBCMS_NORMAL, 4);
      pulse_fail();
      tick(2);
      chk("mode", mode, SBCMS_NORMAL);
      mcu.write_mode(SBCMS_SLEEP);
      wait_mode(SBCMS_SLEEP, 4);
      chk("mode", mode, SBCMS_SLEEP);
   endtask
   task automatic t_failsafe();
      mcu.send_frame(16'h3C5A);
      wait_mode(SBCMS_NORMAL, 4);
      pulse_fail();
      tick(1);
      chk("mode", mode, SBCMS_RESTART);
      wait_mode(SBCMS_NORMAL, TRD + 4);
      pulse_fail();
      tick(1);
      chk("mode", mode, SBCMS_FAILSAFE);
      chk("reg", {2'h0, main_regulator_output}, 3'h0);
      drive_wake(3'h3);
      wait_mode(SBCMS_RESTART, 6);
      chk("mode", mode, SBCMS_RESTART);
      drive_wake(3'h0);
      wait_mode(SBCMS_NORMAL, TRD + 4);
      pulse_fail();
      @(posedge sys_clk);
      overtemp <= 1'b1;
      tick(8);
      chk("mode", mode, SBCMS_FAILSAFE);
      @(posedge sys_clk);
      overtemp <= 1'b0;
      wait_mode(SBCMS_RESTART, 6);
      chk("mode", mode, SBCMS_RESTART);
      wait_mode(SBCMS_NORMAL, TRD + 4);
      @(posedge sys_clk);
      reg_uv_reset <= 1'b1;
      tick(8);
      chk("mode", mode, SBCMS_RESTART);
      chk("rst", {2'h0, mcu_reset_n}, 3'h0);
      @(posedge sys_clk);
      reg_uv_reset <= 1'b0;
      tick(TRD - 2);
      chk("mode", mode, SBCMS_RESTART);
      wait_mode(SBCMS_NORMAL, 6);
      chk("mode", mode, SBCMS_NORMAL);
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      give_verdict();
   end
   initial
   begin
      {resetn, soft_reset, wd_fail, reg_uv_reset, overtemp, cfg_bit} = 6'h0;
      cfg_pin = 1'b1;
      wake_in = 3'h0;
      do_reset(1'b1, 1'b0, 1'b0);
      t_long_window();
      t_init();
      t_modes();
      do_reset(1'b0, 1'b1, 1'b1);
      t_devmode();
      do_reset(1'b0, 1'b0, 1'b0);
      t_failsafe();
      give_verdict();
   end
endmodule
